// ==== hw/isge_pkg.sv ====
// package: register map, field layout, reset values and types of the interrupt selector
package isge_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] SEL_HIGH_ADDR = 32'h019c0000; // lines 10..15
  localparam logic [31:0] SEL_LOW_ADDR = 32'h019c0004; // lines 4..9
  // ----------------------------------------------------------------
  // selector field layout: low bit of each 5-bit field, ascending line
  // ----------------------------------------------------------------
  localparam int FIELD_W = 5;
  localparam int FIELD_LSB [6] = '{0, 5, 10, 16, 21, 26};
  localparam logic [31:0] SEL_WMASK = 32'h7fff7fff; // bits 15 and 31 reserved
  // ----------------------------------------------------------------
  // selector codes
  // ----------------------------------------------------------------
  localparam logic [4:0] SRC_HOST = 5'h00;
  localparam logic [4:0] SRC_TIMER0 = 5'h01;
  localparam logic [4:0] SRC_TIMER1 = 5'h02;
  localparam logic [4:0] SRC_REFRESH = 5'h03;
  localparam logic [4:0] SRC_PIN4 = 5'h04;
  localparam logic [4:0] SRC_PIN5 = 5'h05;
  localparam logic [4:0] SRC_PIN6 = 5'h06;
  localparam logic [4:0] SRC_PIN7 = 5'h07;
  localparam logic [4:0] SRC_XFER = 5'h08;
  localparam logic [4:0] SRC_NONE9 = 5'h09;
  localparam logic [4:0] SRC_NONE10 = 5'h0a;
  localparam logic [4:0] SRC_NONE11 = 5'h0b;
  localparam logic [4:0] SRC_SER0_TX = 5'h0c;
  localparam logic [4:0] SRC_SER0_RX = 5'h0d;
  localparam logic [4:0] SRC_SER1_TX = 5'h0e;
  localparam logic [4:0] SRC_SER1_RX = 5'h0f;
  // reset images of the two selector registers
  localparam logic [31:0] SEL_LOW_RESET = {1'b0, SRC_NONE9, SRC_XFER, SRC_PIN7, 1'b0,
                                           SRC_PIN6, SRC_PIN5, SRC_PIN4};
  localparam logic [31:0] SEL_HIGH_RESET = {1'b0, SRC_TIMER1, SRC_TIMER0, SRC_HOST, 1'b0,
                                            SRC_NONE11, SRC_NONE10, SRC_REFRESH};
  // ----------------------------------------------------------------
  // core control/status layout
  // ----------------------------------------------------------------
  localparam int CCS_GIE = 0;
  localparam int CCS_SAVED_GLOBAL_IRQ_ENABLE = 1;
  localparam int CCS_PWR_LSB = 10;
  localparam logic [5:0] PWR_NONE = 6'h00;
  localparam logic [5:0] PWR_LIGHT_EN = 6'h09;
  localparam logic [5:0] PWR_LIGHT_ANY = 6'h11;
  localparam logic [5:0] PWR_DEEP_A = 6'h1a;
  localparam logic [5:0] PWR_DEEP_B = 6'h1c;
  localparam logic [31:0] CCS_RO_MASK = 32'hffff_fc00; // id + power field read as zero/id
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ISGE_AWAKE, ISGE_LIGHT_EN, ISGE_LIGHT_ANY, ISGE_DEEP} isge_sleep_t;
  typedef struct packed {
    logic [3:0] ext_pin;    // pins 4..7, asynchronous
    logic host_irq;         // host port to processor
    logic timer_zero_irq;
    logic timer_one_irq;
    logic refresh_timer_irq;
    logic transfer_done_irq;
    logic serial0_tx_irq;
    logic serial0_rx_irq;
    logic serial1_tx_irq;
    logic serial1_rx_irq;
  } isge_src_t;
  typedef struct packed {
    logic [31:0] sel_high;
    logic [31:0] sel_low;
    logic global_irq_enable;
    logic saved_global_irq_enable;
    isge_sleep_t sleep;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_q;           // accepted pin levels after filtering
    logic sleep_light;           // registered light sleep flag
    logic sleep_deep;            // registered deep sleep flag
    logic [31:0] ccs;            // registered status image
    logic [15:0] lines;
    logic [31:0] rdata;
  } isge_state_t;
endpackage

// ==== hw/isge_top.sv ====
// interrupt selector with global enable, power-down control and core identity
`timescale 1ns/100ps
// How it works
// - sixteen lines, line 0 highest priority
// - line 0 reset, line 1 nmi, 2-3 reserved
// - lines 0-3 fixed unmasked; 4-15 selectable maskable
// - high selector 0x019c0000, low 0x019c0004
// - 5-bit fields ascending, code picks source
// - lines 4-7 reset to pins 4-7
// - code 01000 transfer done; line 8 default
// - code 00011 refresh timer; line 10 default
// - codes 0,1,2 host, timer0, timer1 defaults
// - lines 9,11,12 default unconnected codes
// - codes 0c-0f serial irqs; 10+ reserved
// - global enable gates maskable lines; resets 0
// - saved enable captures global on take
// - power-down field always reads zero
// - power-down codes enter sleep, wake rules
// - bits 31:16 read-only identity value
module isge_top
  import isge_pkg::*;
#(
  parameter logic [7:0] CPU_ID = 8'h5a,  // arbitrary value
  parameter logic [7:0] REV_ID = 8'h01   // arbitrary value
) (
  input wire logic SYS_CLK,              // 10 MHz core clock
  input wire logic RESET,                // synchronous, active high
  input wire logic CLK_EN,               // low freezes all state
  input wire logic NMI_IN,               // non-maskable event, same clock
  input wire isge_src_t SRC,             // peripheral events and pins
  input wire logic BUS_WR,               // selector register write strobe
  input wire logic BUS_RD,               // selector register read strobe
  input wire logic [31:0] BUS_ADDR,      // selector register address
  input wire logic [31:0] BUS_WDATA,     // write data
  input wire logic CCS_WR,               // core control/status write (core move)
  input wire logic [31:0] CCS_WDATA,     // core control/status write data
  input wire logic IRQ_TAKEN,            // core takes a maskable interrupt
  output logic [31:0] BUS_RDATA,         // selector read data
  output logic [31:0] CCS_RDATA,         // core control/status read value
  output logic [15:0] IRQ_LINES,         // prioritized lines to the core
  output logic SLEEP_LIGHT,              // light sleep active
  output logic SLEEP_DEEP                // deep sleep, reset wakes only
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  isge_state_t r;      // all registered state
  isge_state_t next_r; // next value

  // pick one 5-bit field of a selector register
  function automatic logic [4:0] field(input logic [31:0] reg_v, input int idx);
    field = reg_v[FIELD_LSB[idx] +: FIELD_W];
  endfunction

  // map a selector code to its event; reserved codes give nothing
  function automatic logic route(input logic [4:0] code, input isge_src_t s,
                                 input logic [3:0] pins);
    case (code)
      SRC_HOST: route = s.host_irq;
      SRC_TIMER0: route = s.timer_zero_irq;
      SRC_TIMER1: route = s.timer_one_irq;
      SRC_REFRESH: route = s.refresh_timer_irq;
      SRC_PIN4: route = pins[0];
      SRC_PIN5: route = pins[1];
      SRC_PIN6: route = pins[2];
      SRC_PIN7: route = pins[3];
      SRC_XFER: route = s.transfer_done_irq;
      SRC_SER0_TX: route = s.serial0_tx_irq;
      SRC_SER0_RX: route = s.serial0_rx_irq;
      SRC_SER1_TX: route = s.serial1_tx_irq;
      SRC_SER1_RX: route = s.serial1_rx_irq;
      // codes 09-0b have no source; 10 and above are reserved
      default: route = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // one process computes everything; outputs are all registered below
  always_comb begin
    logic [15:0] raw;
    logic [3:0] pins_ok;
    logic [5:0] pwr;
    raw = '0;
    pins_ok = '0;
    pwr = CCS_WDATA[CCS_PWR_LSB +: 6];
    next_r = r;
    // pin synchroniser: stage 1 is read only by stage 2
    next_r.pin_s1 = SRC.ext_pin;
    next_r.pin_s2 = r.pin_s1;
    next_r.pin_s3 = r.pin_s2;
    // a pin change counts once stages 2 and 3 agree; hold otherwise
    for (int i = 0; i < 4; i++) begin
      pins_ok[i] = (r.pin_s2[i] == r.pin_s3[i]) ? r.pin_s3[i] : r.pin_q[i];
    end
    // keep the accepted levels so a glitch between stages is ignored
    next_r.pin_q = pins_ok;
    // selector register writes, reserved bits kept zero
    if (BUS_WR && BUS_ADDR == SEL_HIGH_ADDR) begin
      next_r.sel_high = BUS_WDATA & SEL_WMASK;
    end
    if (BUS_WR && BUS_ADDR == SEL_LOW_ADDR) begin
      next_r.sel_low = BUS_WDATA & SEL_WMASK;
    end
    // read data: unmapped addresses read zero
    if (BUS_RD) begin
      case (BUS_ADDR)
        SEL_HIGH_ADDR: next_r.rdata = r.sel_high;
        SEL_LOW_ADDR: next_r.rdata = r.sel_low;
        default: next_r.rdata = '0;
      endcase
    end
    // line 0 is reset, line 1 nmi, lines 2-3 reserved and idle
    raw[0] = RESET;
    raw[1] = NMI_IN;
    // lines 4..9 from low register, 10..15 from high register
    for (int k = 0; k < 6; k++) begin
      raw[4 + k] = route(field(r.sel_low, k), SRC, pins_ok);
      raw[10 + k] = route(field(r.sel_high, k), SRC, pins_ok);
    end
    // maskable lines only pass while the global enable is set
    next_r.lines = raw;
    if (!r.global_irq_enable) begin
      next_r.lines[15:4] = '0;
    end
    // external pin lines 4-7 are zeroed too while the global enable is clear
    next_r.lines[7:4] = r.global_irq_enable ? raw[7:4] : '0;
    // core control/status write; power field is not stored
    if (CCS_WR) begin
      next_r.global_irq_enable = CCS_WDATA[CCS_GIE];
      next_r.saved_global_irq_enable = CCS_WDATA[CCS_SAVED_GLOBAL_IRQ_ENABLE];
      case (pwr)
        PWR_LIGHT_EN: next_r.sleep = ISGE_LIGHT_EN;
        PWR_LIGHT_ANY: next_r.sleep = ISGE_LIGHT_ANY;
        PWR_DEEP_A, PWR_DEEP_B: next_r.sleep = ISGE_DEEP;
        default: next_r.sleep = r.sleep;     // none or reserved: no change
      endcase
    end
    // taking an interrupt saves then clears the global enable; wins over a write
    if (IRQ_TAKEN) begin
      next_r.saved_global_irq_enable = r.global_irq_enable;
      next_r.global_irq_enable = 1'b0;
    end
    // wake-up from light sleep; deep sleep leaves only through reset
    case (r.sleep)
      ISGE_LIGHT_EN: if (|next_r.lines[15:4] || raw[1]) next_r.sleep = ISGE_AWAKE;
      ISGE_LIGHT_ANY: if (|raw[15:1]) next_r.sleep = ISGE_AWAKE;
      ISGE_DEEP: next_r.sleep = ISGE_DEEP;
      default: ;
    endcase
    // reset: selector defaults, enables cleared, awake
    if (RESET) begin
      next_r = '0;
      next_r.sel_high = SEL_HIGH_RESET;
      next_r.sel_low = SEL_LOW_RESET;
      next_r.sleep = ISGE_AWAKE;
      next_r.lines[0] = 1'b1;
    end
    // decodes registered here so every output leaves a flop
    next_r.sleep_light = (next_r.sleep == ISGE_LIGHT_EN) || (next_r.sleep == ISGE_LIGHT_ANY);
    next_r.sleep_deep = (next_r.sleep == ISGE_DEEP);
    // identity read-only, power field reads zero
    next_r.ccs = {CPU_ID, REV_ID, 6'h00, 8'h00,
                  next_r.saved_global_irq_enable, next_r.global_irq_enable};
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // clock enable freezes everything, reset included
  always_ff @(posedge SYS_CLK) begin
    if (CLK_EN) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a plain copy of a state flop; the clock enable freezes them all
  assign CCS_RDATA = r.ccs;
  assign BUS_RDATA = r.rdata;
  assign IRQ_LINES = r.lines;
  assign SLEEP_LIGHT = r.sleep_light;
  assign SLEEP_DEEP = r.sleep_deep;
endmodule

// ==== tb/isge_partner.sv ====
// stand-in for the peripherals, pins and core around the selector
`timescale 1ns/100ps
module isge_partner
  import isge_pkg::*;
(
  input wire logic clk, // core clock
  input wire isge_src_t ev, // events the bench wants raised
  input wire logic nmi, // nmi request
  input wire logic take, // core take request
  output isge_src_t src, // events toward the block
  output logic nmi_o, // nmi toward the block
  output logic taken // take pulse toward the block
);
  // launch just after the edge, like same-clock peripheral logic would
  always_ff @(posedge clk) begin
    src <= ev;
    nmi_o <= nmi;
    taken <= take;
  end
endmodule

// ==== tb/isge_assertions.sv ====
// checker: port relations of the interrupt selector block
`timescale 1ns/100ps
module isge_assertions
  import isge_pkg::*;
#(
  parameter logic [7:0] CPU_ID = 8'h5a,
  parameter logic [7:0] REV_ID = 8'h01
) (
  input wire logic SYS_CLK, // core clock
  input wire logic RESET, // sync reset
  input wire logic CLK_EN, // clock enable
  input wire logic NMI_IN, // nmi level
  input wire logic BUS_RD, // read strobe
  input wire logic [31:0] BUS_ADDR, // address
  input wire logic CCS_WR, // status write
  input wire logic [31:0] CCS_WDATA, // status data
  input wire logic IRQ_TAKEN, // take pulse
  input wire logic [31:0] BUS_RDATA, // read data
  input wire logic [31:0] CCS_RDATA, // status value
  input wire logic [15:0] IRQ_LINES, // lines
  input wire logic SLEEP_LIGHT, // light sleep
  input wire logic SLEEP_DEEP // deep sleep
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // an edge that really moves state
  wire logic go = CLK_EN && !RESET;
  a_reset_line: assert property (disable iff (1'b0) RESET && CLK_EN |=> IRQ_LINES == 16'h0001)
    else $error("line 0 not alone during reset");
  a_nmi_follow: assert property (go |=> IRQ_LINES[1] == $past(NMI_IN))
    else $error("nmi line lags wrong");
  a_reserved_zero: assert property (IRQ_LINES[3:2] == 2'b00)
    else $error("reserved line raised");
  a_mask_block: assert property (go && !CCS_RDATA[0] && !CCS_WR |=> IRQ_LINES[15:4] == 12'h000)
    else $error("maskable line while disabled");
  a_take_save: assert property (go && IRQ_TAKEN |=> CCS_RDATA[1:0] == {$past(CCS_RDATA[0]), 1'b0})
    else $error("take did not save and clear");
  a_status_write: assert property (go && CCS_WR && !IRQ_TAKEN |=> CCS_RDATA[1:0] == $past(CCS_WDATA[1:0]))
    else $error("enable write lost");
  a_ident_fixed: assert property (go |=> CCS_RDATA[31:16] == {CPU_ID, REV_ID})
    else $error("identity changed");
  a_unmapped_zero: assert property (go && BUS_RD && BUS_ADDR != SEL_HIGH_ADDR && BUS_ADDR != SEL_LOW_ADDR |=> BUS_RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_deep_holds: assert property (go && SLEEP_DEEP |=> SLEEP_DEEP [*3])
    else $error("deep sleep left without reset");
  a_rdata_holds: assert property (go && !BUS_RD |=> $stable(BUS_RDATA))
    else $error("read data moved without read");
  c_take: cover property (go && IRQ_TAKEN);
  c_deep: cover property (SLEEP_DEEP);
  c_wake: cover property (SLEEP_LIGHT ##1 !SLEEP_LIGHT);
endmodule
bind isge_top isge_assertions #(.CPU_ID(CPU_ID), .REV_ID(REV_ID)) i_isge_assertions (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .CLK_EN(CLK_EN), .NMI_IN(NMI_IN), .BUS_RD(BUS_RD),
  .BUS_ADDR(BUS_ADDR), .CCS_WR(CCS_WR), .CCS_WDATA(CCS_WDATA), .IRQ_TAKEN(IRQ_TAKEN),
  .BUS_RDATA(BUS_RDATA), .CCS_RDATA(CCS_RDATA), .IRQ_LINES(IRQ_LINES),
  .SLEEP_LIGHT(SLEEP_LIGHT), .SLEEP_DEEP(SLEEP_DEEP));

// ==== tb/tb.sv ====
// self-checking bench for the interrupt selector block
`timescale 1ns/100ps
module tb
  import isge_pkg::*;
();
  typedef struct packed {logic [1:0] s; logic [31:0] v;} isge_exp_t;
  localparam logic [15:0] ID = 16'h5a01; // arbitrary identity
  logic clk = 1'b0, rst = 1'b1, bwr = 1'b0, brd = 1'b0, cwr = 1'b0, nmi = 1'b0, take = 1'b0;
  logic [31:0] addr = '0, wdata = '0, cdata = '0, rdata, crd, d, g;
  logic [15:0] lines;
  logic sl, sd, nmi_o, taken;
  isge_src_t ev = '0, src;
  isge_exp_t q[$], e;
  int n_fail = 0, total_checks = 0, seed = 32'h66ce9d3f;
  always #50 clk = ~clk;
  isge_partner i_isge_partner (.clk(clk), .ev(ev), .nmi(nmi), .take(take), .src(src),
    .nmi_o(nmi_o), .taken(taken));
  isge_top #(.CPU_ID(ID[15:8]), .REV_ID(ID[7:0])) i_isge_top (.SYS_CLK(clk), .RESET(rst),
    .CLK_EN(1'b1), .NMI_IN(nmi_o), .SRC(src), .BUS_WR(bwr), .BUS_RD(brd), .BUS_ADDR(addr),
    .BUS_WDATA(wdata), .CCS_WR(cwr), .CCS_WDATA(cdata), .IRQ_TAKEN(taken), .BUS_RDATA(rdata),
    .CCS_RDATA(crd), .IRQ_LINES(lines), .SLEEP_LIGHT(sl), .SLEEP_DEEP(sd));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic put(input logic [1:0] s, input logic [31:0] v);
    q.push_back('{s, v});
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    bwr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    bwr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    brd <= 1'b1; addr <= a;
    @(posedge clk);
    brd <= 1'b0;
    put(2'd0, v);
  endtask
  task automatic ccs(input logic [31:0] v);
    @(posedge clk);
    cwr <= 1'b1; cdata <= v;
    @(posedge clk);
    cwr <= 1'b0;
  endtask
  function automatic logic [31:0] rep(input logic [4:0] c);
    return {1'b0, c, c, c, 1'b0, c, c, c};
  endfunction
  // one source per selector code; codes 9..11 reach nothing
  function automatic isge_src_t src_of(input logic [4:0] c);
    isge_src_t s;
    s = '0;
    case (c)
      5'h00: s.host_irq = 1'b1;
      5'h01: s.timer_zero_irq = 1'b1;
      5'h02: s.timer_one_irq = 1'b1;
      5'h03: s.refresh_timer_irq = 1'b1;
      5'h04, 5'h05, 5'h06, 5'h07: s.ext_pin[c[1:0]] = 1'b1;
      5'h08: s.transfer_done_irq = 1'b1;
      5'h0c: s.serial0_tx_irq = 1'b1;
      5'h0d: s.serial0_rx_irq = 1'b1;
      5'h0e: s.serial1_tx_irq = 1'b1;
      5'h0f: s.serial1_rx_irq = 1'b1;
      default: s = '0;
    endcase
    return s;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watcher: compare settled outputs against the oldest notes
  always @(negedge clk) begin
    while (q.size() > 0) begin
      e = q.pop_front();
      g = e.s == 2'd0 ? rdata : e.s == 2'd1 ? crd : e.s == 2'd2 ? {16'h0, lines} : {30'h0, sd, sl};
      total_checks++;
      if (g !== e.v) begin
        n_fail++;
        $display("[FAIL] %0t got %h exp %h", $time, g, e.v);
      end
    end
  end
  initial begin
    tick(10);
    rst <= 1'b0;
    rd(SEL_HIGH_ADDR, {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0b, 5'h0a, 5'h03});
    rd(SEL_LOW_ADDR, {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04});
    rd(32'h019c0008, 32'h0);
    put(2'd1, {ID, 16'h0000});
    put(2'd2, 32'h0);
    // legal codes only, with the reserved gap bits set to see them dropped
    for (int i = 0; i < 6; i++) begin
      d = ($random(seed) & 32'h3def3def) | 32'h80008000;
      wr(i[0] ? SEL_HIGH_ADDR : SEL_LOW_ADDR, d);
      rd(i[0] ? SEL_HIGH_ADDR : SEL_LOW_ADDR, d & 32'h7fff7fff);
    end
    $display("test reset and registers done");
    ccs(32'h1);
    for (int c = 0; c < 16; c++) begin
      wr(SEL_LOW_ADDR, rep(c[4:0]));
      wr(SEL_HIGH_ADDR, rep(c[4:0]));
      ev <= src_of(c[4:0]);
      tick(6);
      put(2'd2, (c inside {9, 10, 11}) ? 32'h0 : 32'hfff0);
      ev <= '0;
      tick(6);
    end
    ev <= src_of(5'h0f);
    ccs(32'h0);
    tick(3);
    put(2'd2, 32'h0);
    nmi <= 1'b1;
    tick(3);
    put(2'd2, 32'h0002);
    nmi <= 1'b0;
    ev <= '0;
    $display("test routing done");
    ccs(32'h1);
    for (int k = 0; k < 2; k++) begin
      take <= 1'b1;
      tick(1);
      take <= 1'b0;
      tick(3);
      put(2'd1, {ID, 14'h0, ~k[0], 1'b0});
    end
    $display("test take done");
    ccs(32'h0400);
    put(2'd3, 32'h0);
    ccs(32'h2400);
    put(2'd3, 32'h1);
    put(2'd1, {ID, 16'h0000});
    nmi <= 1'b1;
    tick(3);
    put(2'd3, 32'h0);
    nmi <= 1'b0;
    ccs(32'h4400);
    ev <= src_of(5'h0f);
    put(2'd3, 32'h1);
    tick(8);
    put(2'd3, 32'h0);
    for (int k = 0; k < 2; k++) begin
      ccs(k[0] ? 32'h7000 : 32'h6800);
      put(2'd3, 32'h2);
      nmi <= 1'b1;
      tick(4);
      put(2'd3, 32'h2);
      nmi <= 1'b0;
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      put(2'd3, 32'h0);
    end
    ev <= '0;
    $display("test power-down done");
    tick(2);
    tally_and_finish;
  end
  initial begin
    tick(20000);
    n_fail++;
    tally_and_finish;
  end
endmodule
